// ===== design/mmsh_handler.sv
// MIDI mute and snapshot handler: mute pairs and Program Change out, Note On and Program Change in.
module mmsh_handler #(
   parameter int FLASH_CYCLES = mmsh_pkg::FLASH_HALF_CYC,   // Lamp half period in cycles.
   parameter int BOOT_CYCLES  = mmsh_pkg::BOOT_CHECK_CYC    // Boot check length in cycles.
) (
   // Clock and reset.
   input  wire logic                        clk_sys,
   input  wire logic                        rst_n,
   // Received MIDI bytes from the port receiver.
   input  wire logic                        rx_valid,
   input  wire logic [7:0]                  rx_byte,
   // Transmitted MIDI bytes to the port transmitter.
   input  wire logic                        tx_ready,
   output      logic                        tx_valid,
   output      logic [7:0]                  tx_byte,
   // Front panel events from the panel scanner.
   input  wire logic                        mute_key_press,
   input  wire logic [6:0]                  mute_key_note,
   input  wire logic                        snap_recall_req,
   input  wire logic [6:0]                  snap_recall_prog,
   // Switch pins.
   input  wire logic                        channel_select_key,
   input  wire logic                        port_select_serial,
   // Status toward the console.
   output      logic [mmsh_pkg::MUTE_COUNT-1:0] mute_state,
   output      logic [3:0]                  midi_channel,
   output      logic [15:0]                 group_membership_lamp,
   output      logic                        snap_recall_pulse,
   output      logic [6:0]                  snapshot_program_value,
   output      logic                        boot_busy
);
   import mmsh_pkg::*;

   mmsh_state_t s_r;     // Registered state.
   mmsh_state_t s_nxt;   // Next state.
   logic        key_ok;  // Mute key press that toggles and sends.
   logic        key_sel; // Mute key press that selects the channel.
   logic        key_was_muted; // Mute of the pressed key before the press.
   logic        rx_apply;      // Received velocity byte acting on a mute.
   logic [5:0]  rx_idx;        // Mute index of the received note.

   // True when a note lies in the mute map.
   function automatic logic note_in_map(input logic [6:0] note);
      note_in_map = (note >= NOTE_FIRST) && (note <= NOTE_LAST);
   endfunction

   // Mute index of a mapped note.
   function automatic logic [5:0] note_idx(input logic [6:0] note);
      logic [6:0] d;
      d = note - NOTE_FIRST;
      note_idx = d[5:0];
   endfunction

   // Byte of the current message at a given step.
   function automatic logic [7:0] msg_byte(input mmsh_tx_t kind, input logic [2:0] step,
                                           input logic [3:0] ch, input logic [6:0] note,
                                           input logic [6:0] vel, input logic [6:0] prog);
      msg_byte = VEL_ZERO;
      if (kind == MMSH_TX_PROG) begin
         msg_byte = (step == 3'h0) ? {PROG_CHG_HI, ch} : {1'b0, prog};
      end else begin
         case (step)
            3'h0, 3'h3: msg_byte = {NOTE_ON_HI, ch};
            3'h1, 3'h4: msg_byte = {1'b0, note};
            3'h2:       msg_byte = {1'b0, vel};
            default:    msg_byte = VEL_ZERO;
         endcase
      end
   endfunction

   // Front panel and receive decode shared by the next state logic and the checks.
   always_comb begin
      key_sel = mute_key_press && !s_r.booting && !s_r.tx_valid && s_r.sel_held
                && note_in_map(mute_key_note) && (mute_key_note <= NOTE_CH16);
      key_ok  = mute_key_press && !s_r.booting && !s_r.tx_valid && !s_r.sel_held
                && note_in_map(mute_key_note);
      key_was_muted = s_r.mute[note_idx(mute_key_note)];
      rx_idx   = note_idx(s_r.rx_note);
      rx_apply = rx_valid && !s_r.booting && !rx_byte[7] && (s_r.run == MMSH_RUN_NOTE)
                 && s_r.rx_second && note_in_map(s_r.rx_note);
   end

   // Next state of the whole handler.
   always_comb begin
      s_nxt = s_r;
      s_nxt.recall_p = 1'b0;
      // Pins pass three flops; a change counts once the last two agree.
      s_nxt.sel_sync = {s_r.sel_sync[1:0], channel_select_key};
      s_nxt.ser_sync = {s_r.ser_sync[1:0], port_select_serial};
      if (s_r.sel_sync[2] == s_r.sel_sync[1]) begin
         s_nxt.sel_held = s_r.sel_sync[1];
      end
      if (s_r.ser_sync[2] == s_r.ser_sync[1]) begin
         s_nxt.ser_sel = s_r.ser_sync[1];
      end
      // The serial selector is read once it has settled, then the check runs.
      if (s_r.booting) begin
         s_nxt.boot_cnt = s_r.boot_cnt + 24'h000001;
         if ((s_r.boot_cnt >= BOOT_SETTLE) && !s_r.ser_sel) begin
            s_nxt.booting = 1'b0;
         end
         if (s_r.boot_cnt >= BOOT_CYCLES[23:0]) begin
            s_nxt.booting = 1'b0;
         end
      end
      // Free running flash phase for the channel lamp.
      if (s_r.flash_cnt >= FLASH_CYCLES[23:0] - 24'h000001) begin
         s_nxt.flash_cnt = 24'h000000;
         s_nxt.flash_on  = !s_r.flash_on;
      end else begin
         s_nxt.flash_cnt = s_r.flash_cnt + 24'h000001;
      end
      // The lamp of the selected channel flashes while the select key is held.
      s_nxt.lamp = 16'h0000;
      if (s_r.sel_held && s_r.flash_on) begin
         s_nxt.lamp[s_r.chan] = 1'b1;
      end
      // Each accepted byte advances the message; the last one frees the sender.
      if (s_r.tx_valid && tx_ready) begin
         if (s_r.tx_step == ((s_r.tx_st == MMSH_TX_PROG) ? PROG_LAST_STEP : NOTE_LAST_STEP)) begin
            s_nxt.tx_st    = MMSH_TX_IDLE;
            s_nxt.tx_valid = 1'b0;
            s_nxt.tx_step  = 3'h0;
            s_nxt.tx_byte  = VEL_ZERO;
         end else begin
            // Mid message: offer the next byte of the same message.
            s_nxt.tx_step = s_r.tx_step + 3'h1;
            s_nxt.tx_byte = msg_byte(s_r.tx_st, s_r.tx_step + 3'h1, s_r.chan,
                                     s_r.tx_note, s_r.tx_vel, s_r.tx_prog);
         end
      end
      // Front panel events, taken only while the sender is idle.
      if (key_sel) begin
         s_nxt.chan = mute_key_note[3:0];
      end else if (key_ok) begin
         s_nxt.mute[note_idx(mute_key_note)] = !key_was_muted;
         s_nxt.tx_st    = MMSH_TX_NOTE;
         s_nxt.tx_step  = 3'h0;
         s_nxt.tx_valid = 1'b1;
         s_nxt.tx_note  = mute_key_note;
         s_nxt.tx_vel   = key_was_muted ? VEL_MUTE_OFF[6:0] : VEL_MUTE_ON[6:0];
         s_nxt.tx_byte  = {NOTE_ON_HI, s_r.chan};
      end else if (snap_recall_req && !s_r.booting && !s_r.tx_valid && !mute_key_press) begin
         s_nxt.tx_st    = MMSH_TX_PROG;
         s_nxt.tx_step  = 3'h0;
         s_nxt.tx_valid = 1'b1;
         s_nxt.tx_prog  = snap_recall_prog;
         s_nxt.tx_byte  = {PROG_CHG_HI, s_r.chan};
      end
      // Receiver; it only knows mutes and snapshots, nothing of groups.
      if (rx_valid && !s_r.booting) begin
         if (rx_byte[7]) begin
            if (rx_byte < REALTIME_LO) begin
               // A status for another channel or type cancels running status.
               s_nxt.rx_second = 1'b0;
               if (rx_byte == {NOTE_ON_HI, s_r.chan}) begin
                  s_nxt.run = MMSH_RUN_NOTE;
               end else if (rx_byte == {PROG_CHG_HI, s_r.chan}) begin
                  s_nxt.run = MMSH_RUN_PROG;
               end else begin
                  s_nxt.run = MMSH_RUN_NONE;
               end
            end
         end else begin
            case (s_r.run)
               MMSH_RUN_NOTE: begin
                  // Data bytes alternate note and velocity under running status.
                  s_nxt.rx_second = !s_r.rx_second;
                  if (!s_r.rx_second) begin
                     s_nxt.rx_note = rx_byte[6:0];
                  end else if (rx_apply && (rx_byte != VEL_ZERO)) begin
                     s_nxt.mute[rx_idx] = (rx_byte >= VEL_ON_MIN);
                  end
               end
               MMSH_RUN_PROG: begin
                  s_nxt.recall_p    = 1'b1;
                  s_nxt.recall_prog = rx_byte[6:0];
               end
               default: begin
                  // Data with no running status is dropped.
                  s_nxt.rx_second = 1'b0;
               end
            endcase
         end
      end
   end

   // State register.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Everything clears; only the boot check starts busy.
         s_r         <= '0;
         s_r.booting <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign tx_valid               = s_r.tx_valid;
   assign tx_byte                = s_r.tx_byte;
   assign mute_state             = s_r.mute;
   assign midi_channel           = s_r.chan;
   assign group_membership_lamp  = s_r.lamp;
   assign snap_recall_pulse      = s_r.recall_p;
   assign snapshot_program_value = s_r.recall_prog;
   assign boot_busy              = s_r.booting;

   // Both status bytes of a mute pair carry the console channel.
   AST_NOTE_STATUS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_r.tx_valid && (s_r.tx_st == MMSH_TX_NOTE)
      && ((s_r.tx_step == 3'h0) || (s_r.tx_step == 3'h3))
      |-> (s_r.tx_byte == {NOTE_ON_HI, s_r.chan}))
      else $error("Note On status byte wrong");

   // A Program Change is Cn followed by the program.
   AST_PROG_MSG: assert property (@(posedge clk_sys) disable iff (!rst_n)
      snap_recall_req && !mute_key_press && !s_r.booting && !s_r.tx_valid
      |=> s_r.tx_valid && (s_r.tx_st == MMSH_TX_PROG)
      && (s_r.tx_byte == {PROG_CHG_HI, s_r.chan}) && (s_r.tx_prog == $past(snap_recall_prog)))
      else $error("Program Change status wrong");

   // The sixth byte of a pair is velocity zero.
   AST_SECOND_VEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_r.tx_valid && (s_r.tx_st == MMSH_TX_NOTE) && (s_r.tx_step == NOTE_LAST_STEP)
      |-> (s_r.tx_byte == VEL_ZERO))
      else $error("Second Note On velocity not zero");

   // The first velocity reflects the new mute state.
   AST_FIRST_VEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      key_ok |=> s_r.tx_valid && (s_r.tx_vel == ($past(key_was_muted) ? 7'h3F : 7'h7F)))
      else $error("First velocity does not match mute state");

   // Nonzero received velocities below 40h clear the mute, 40h and above set it.
   AST_RX_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_apply && (rx_byte != VEL_ZERO)
      |=> (s_r.mute[$past(rx_idx)] == $past(rx_byte[6])))
      else $error("Received velocity acted wrongly on mute");

   // Velocity zero leaves every mute as it was.
   AST_RX_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_apply && (rx_byte == VEL_ZERO) && !key_ok |=> $stable(s_r.mute))
      else $error("Velocity zero changed a mute");

   // A key under channel select neither sends nor toggles, and sets the channel.
   AST_SEL_KEY: assert property (@(posedge clk_sys) disable iff (!rst_n)
      key_sel && !rx_apply |=> !s_r.tx_valid && $stable(s_r.mute)
      && (s_r.chan == $past(mute_key_note[3:0])))
      else $error("Channel select key misbehaved");

   // Nothing is sent while the boot check runs.
   AST_BOOT_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_r.booting |-> !s_r.tx_valid && !s_r.recall_p)
      else $error("Traffic during boot check");

   // A remote recall is a single cycle pulse.
   AST_RECALL_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_r.recall_p |=> !s_r.recall_p || $past(rx_valid))
      else $error("Recall pulse too long");

   // The byte after Cn is the held program value.
   AST_PROG_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_r.tx_valid && (s_r.tx_st == MMSH_TX_PROG) && (s_r.tx_step == PROG_LAST_STEP)
      |-> (s_r.tx_byte == {1'b0, s_r.tx_prog}))
      else $error("Program byte wrong");

   // Bytes two and five of a pair carry the key's note.
   AST_NOTE_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_r.tx_valid && (s_r.tx_st == MMSH_TX_NOTE)
      && ((s_r.tx_step == 3'h1) || (s_r.tx_step == 3'h4))
      |-> (s_r.tx_byte == {1'b0, s_r.tx_note}))
      else $error("Pair note byte wrong");

   // The third byte of a pair is the first velocity.
   AST_NOTE_VEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_r.tx_valid && (s_r.tx_st == MMSH_TX_NOTE) && (s_r.tx_step == 3'h2)
      |-> (s_r.tx_byte == {1'b0, s_r.tx_vel}))
      else $error("Pair velocity byte wrong");

   // A byte not yet taken stays offered unchanged.
   AST_TX_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_r.tx_valid && !tx_ready
      |=> s_r.tx_valid && $stable(s_r.tx_byte) && $stable(s_r.tx_step))
      else $error("Offered byte changed early");

   // An accepted key toggles its mute and starts a pair.
   AST_KEY_SEND: assert property (@(posedge clk_sys) disable iff (!rst_n)
      key_ok && !rx_apply |=> s_r.tx_valid && (s_r.tx_note == $past(mute_key_note))
      && (s_r.mute[note_idx($past(mute_key_note))] != $past(key_was_muted)))
      else $error("Mute key did not toggle and send");

   // A status byte for another channel drops running status.
   AST_FOREIGN_CHAN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_valid && !s_r.booting && rx_byte[7] && (rx_byte < REALTIME_LO)
      && (rx_byte[3:0] != s_r.chan) |=> (s_r.run == MMSH_RUN_NONE))
      else $error("Foreign status taken");

   // A program byte raises the recall with its value.
   AST_RECALL_VALUE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_valid && !s_r.booting && !rx_byte[7] && (s_r.run == MMSH_RUN_PROG)
      |=> s_r.recall_p && (s_r.recall_prog == $past(rx_byte[6:0])))
      else $error("Remote recall wrong");

   // Realtime bytes leave the receive pairing alone.
   AST_REALTIME: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_valid && (rx_byte >= REALTIME_LO) |=> $stable(s_r.run) && $stable(s_r.rx_second))
      else $error("Realtime byte disturbed receive");

   // While select is held the channel's lamp flashes.
   AST_LAMP_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_r.sel_held && s_r.flash_on |=> (s_r.lamp == (16'h0001 << $past(s_r.chan))))
      else $error("Channel lamp wrong");

   // With select released every lamp is dark.
   AST_LAMP_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !s_r.sel_held |=> (s_r.lamp == 16'h0000))
      else $error("Lamp lit without select");

   // With the serial selector the check runs its full length.
   AST_BOOT_SERIAL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_r.booting && s_r.ser_sel && (s_r.boot_cnt < BOOT_CYCLES[23:0]) |=> s_r.booting)
      else $error("Serial boot check ended early");

endmodule

// ===== design/mmsh_pkg.sv
// Constants, enumerations and the state record of the MIDI mute and snapshot handler.
package mmsh_pkg;

   // Clock rate and derived cycle counts.
   localparam int CLK_HZ          = 10_000_000;         // System clock rate in hertz.
   localparam int CYC_PER_MS      = CLK_HZ / 1000;      // Clock cycles in one millisecond.
   localparam int FLASH_HALF_MS   = 250;                // Lamp flash half period in ms.
   localparam int FLASH_HALF_CYC  = FLASH_HALF_MS * CYC_PER_MS;
   localparam int BOOT_CHECK_MS   = 500;                // Serial code update check time in ms.
   localparam int BOOT_CHECK_CYC  = BOOT_CHECK_MS * CYC_PER_MS;
   localparam logic [23:0] BOOT_SETTLE = 24'h000005;   // Cycles until the selector is known.

   // MIDI message encodings.
   localparam logic [3:0] NOTE_ON_HI  = 4'h9;          // Note On status, high nibble.
   localparam logic [3:0] PROG_CHG_HI = 4'hC;          // Program Change status, high nibble.
   localparam logic [7:0] REALTIME_LO = 8'hF8;         // First single byte realtime status.
   localparam logic [7:0] VEL_MUTE_ON = 8'h7F;         // Sent velocity for mute on.
   localparam logic [7:0] VEL_MUTE_OFF= 8'h3F;         // Sent velocity for mute off.
   localparam logic [7:0] VEL_ZERO    = 8'h00;         // Second velocity, also ignored on receive.
   localparam logic [7:0] VEL_ON_MIN  = 8'h40;         // Lowest received velocity that mutes.

   // Mute note map.
   localparam logic [6:0] NOTE_FIRST  = 7'h20;         // Note of channel 1.
   localparam logic [6:0] NOTE_LAST   = 7'h51;         // Note of stereo inputs 3-4.
   localparam logic [6:0] NOTE_CH16   = 7'h2F;         // Note of channel 16.
   localparam int         MUTE_COUNT  = 50;            // Mutes in the note map.

   // Transmit byte steps.
   localparam logic [2:0] NOTE_LAST_STEP = 3'h5;       // Six bytes in a mute pair.
   localparam logic [2:0] PROG_LAST_STEP = 3'h1;       // Two bytes in a Program Change.

   // Kind of message being transmitted.
   typedef enum logic [1:0] {
      MMSH_TX_IDLE = 2'b00,
      MMSH_TX_NOTE = 2'b01,
      MMSH_TX_PROG = 2'b10
   } mmsh_tx_t;

   // Running status held by the receiver.
   typedef enum logic [1:0] {
      MMSH_RUN_NONE = 2'b00,
      MMSH_RUN_NOTE = 2'b01,
      MMSH_RUN_PROG = 2'b10
   } mmsh_run_t;

   // Complete state of the handler.
   typedef struct packed {
      logic [MUTE_COUNT-1:0] mute;         // Mute state, bit 0 is note 20h.
      logic [3:0]            chan;         // Selected MIDI channel, 0 is channel 1.
      mmsh_tx_t              tx_st;        // Message kind in transmission.
      logic [2:0]            tx_step;      // Byte index within the message.
      logic                  tx_valid;     // Byte offered on the output.
      logic [7:0]            tx_byte;      // Byte offered on the output.
      logic [6:0]            tx_note;      // Note of the mute pair.
      logic [6:0]            tx_vel;       // First velocity of the mute pair.
      logic [6:0]            tx_prog;      // Program value being sent.
      mmsh_run_t             run;          // Receive running status.
      logic                  rx_second;    // Next data byte is a velocity.
      logic [6:0]            rx_note;      // Received note number.
      logic                  recall_p;     // Remote recall pulse.
      logic [6:0]            recall_prog;  // Remote recall program value.
      logic [2:0]            sel_sync;     // Channel select key synchroniser.
      logic                  sel_held;     // Filtered channel select key.
      logic [2:0]            ser_sync;     // Rear selector synchroniser.
      logic                  ser_sel;      // Filtered rear selector, 1 is serial.
      logic                  booting;      // Boot check in progress.
      logic [23:0]           boot_cnt;     // Boot check cycle count.
      logic [23:0]           flash_cnt;    // Lamp flash cycle count.
      logic                  flash_on;     // Lamp flash phase.
      logic [15:0]           lamp;         // Channel indicator lamps.
   } mmsh_state_t;

endpackage

// ===== tb/midi_mute_snapshot_handler_test.sv
// Self-checking bench of the MIDI mute and snapshot handler.
module midi_mute_snapshot_handler_test;
   timeunit 1ns;
   timeprecision 1ns;
   import mmsh_pkg::*;

   // One receive case: bytes sent, then the bit or program value expected.
   typedef struct packed {
      logic [7:0] b0;
      logic [7:0] b1;
      logic [7:0] b2;
      logic       two;   // Two byte Program Change case.
      logic [6:0] idx;   // Mute bit to check, or expected program.
      logic       val;   // Expected mute bit, or expected recall pulse.
   } mmsh_row_t;

   localparam mmsh_row_t ROWS [10] = '{
      '{8'h90, 8'h30, 8'h45, 1'b0, 7'd16, 1'b1},
      '{8'h90, 8'h30, 8'h00, 1'b0, 7'd16, 1'b1},
      '{8'h90, 8'h30, 8'h3F, 1'b0, 7'd16, 1'b0},
      '{8'h90, 8'h20, 8'h40, 1'b0, 7'd0,  1'b1},
      '{8'h90, 8'h51, 8'h7F, 1'b0, 7'd49, 1'b1},
      '{8'h90, 8'h50, 8'h7F, 1'b0, 7'd48, 1'b1},
      '{8'h91, 8'h20, 8'h10, 1'b0, 7'd0,  1'b1},
      '{8'hC0, 8'h05, 8'h00, 1'b1, 7'h05, 1'b1},
      '{8'hC0, 8'h7F, 8'h00, 1'b1, 7'h7F, 1'b1},
      '{8'hC1, 8'h03, 8'h00, 1'b1, 7'h7F, 1'b0}
   };

   // Design pins and bench controls.
   logic                  clk_sys = 1'b0;
   logic                  rst_n, rx_valid, tx_ready, tx_valid, mute_key_press;
   logic                  snap_recall_req, channel_select_key, port_select_serial;
   logic                  snap_recall_pulse, boot_busy, slow, clr;
   logic [7:0]            rx_byte, tx_byte;
   logic [6:0]            mute_key_note, snap_recall_prog, snapshot_program_value;
   logic [MUTE_COUNT-1:0] mute_state;
   logic [3:0]            midi_channel, n_got;
   logic [15:0]           group_membership_lamp;
   logic [63:0]           got_bytes;
   int                    n_errors = 0;
   int                    n_tests = 0;

   // The clock flips every half period of 50 ns.
   always #50 clk_sys = ~clk_sys;

   // Short counts keep the flash and boot checks quick.
   mmsh_handler #(.FLASH_CYCLES(8), .BOOT_CYCLES(20)) DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .mute_key_press(mute_key_press), .mute_key_note(mute_key_note),
      .snap_recall_req(snap_recall_req), .snap_recall_prog(snap_recall_prog),
      .channel_select_key(channel_select_key), .port_select_serial(port_select_serial),
      .mute_state(mute_state), .midi_channel(midi_channel),
      .group_membership_lamp(group_membership_lamp), .snap_recall_pulse(snap_recall_pulse),
      .snapshot_program_value(snapshot_program_value), .boot_busy(boot_busy));

   // The far side transmitter, prompt or slow.
   mmsh_midi_sink sink (
      .clk_sys(clk_sys), .rst_n(rst_n), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_ready(tx_ready), .slow(slow), .clr(clr), .got_bytes(got_bytes), .n_got(n_got));

   // Steps to just after the next rising edge, where inputs change.
   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask

   // Prints the verdict and stops the run.
   task automatic print_verdict;
      if (n_errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Compares a value with its expectation and reports a difference.
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
         n_errors++;
      end
   endtask

   // A wait that ran out counts as an error and ends the run.
   task automatic give_up;
      n_errors++;
      print_verdict();
   endtask

   // Presents one received byte for one cycle; the caller lowers rx_valid.
   task automatic rx(input logic [7:0] b);
      rx_valid = 1'b1;
      rx_byte  = b;
      tick();
   endtask

   // Waits, bounded, until the handler has finished sending.
   task automatic wait_tx_idle;
      for (int i = 0; i < 200 && tx_valid !== 1'b0; i++) tick();
      if (tx_valid !== 1'b0) give_up();
   endtask

   // Waits, bounded, until the boot check is over.
   task automatic wait_boot;
      for (int i = 0; i < 60 && boot_busy !== 1'b0; i++) tick();
      if (boot_busy !== 1'b0) give_up();
      tick();
   endtask

   // Waits, bounded, for the flashing lamp pattern.
   task automatic wait_lamp(input logic [15:0] exp);
      for (int i = 0; i < 40 && group_membership_lamp !== exp; i++) tick();
      check(group_membership_lamp, exp);
   endtask

   // Pulses a mute key and clears the far side byte count.
   task automatic press(input logic [6:0] note);
      clr            = 1'b1;
      mute_key_press = 1'b1;
      mute_key_note  = note;
      tick();
      mute_key_press = 1'b0;
      clr            = 1'b0;
   endtask

   // Presses a mute key and checks the whole six byte pair.
   task automatic mute_pair(input logic [7:0] st, input logic [6:0] note,
                            input logic [7:0] vel);
      press(note);
      wait_tx_idle();
      check({n_got, got_bytes[47:0]}, {4'h6, st, 1'b0, note, vel, st, 1'b0, note, 8'h00});
   endtask

   // Main sequence: reset, table of receive cases, then hand-written cases.
   initial begin
      {rst_n, rx_valid, mute_key_press, snap_recall_req, channel_select_key} = 5'h00;
      {port_select_serial, slow, clr} = 3'h0;
      rx_byte          = 8'h00;
      mute_key_note    = 7'h20;
      snap_recall_prog = 7'h00;
      repeat (4) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      check({boot_busy, midi_channel, mute_state}, {1'b1, 4'h0, 50'h0});
      wait_boot();
      foreach (ROWS[k]) begin
         rx(ROWS[k].b0);
         rx(ROWS[k].b1);
         if (!ROWS[k].two) rx(ROWS[k].b2);
         rx_valid = 1'b0;
         if (ROWS[k].two)
            check({snapshot_program_value, snap_recall_pulse}, ROWS[k][7:0]);
         else
            check(mute_state[ROWS[k].idx], ROWS[k].val);
         tick();
         check(snap_recall_pulse, 1'b0);
      end
      // Running status with a realtime byte in between.
      rx(8'h90);
      rx(8'h21);
      rx(8'h7F);
      rx(8'h22);
      rx(8'h40);
      rx(8'hF8);
      rx(8'h23);
      rx(8'h7F);
      rx_valid = 1'b0;
      check(mute_state[3:1], 3'h7);
      tick();
      rx(8'hC0);
      rx(8'h06);
      rx(8'h07);
      rx_valid = 1'b0;
      check({snap_recall_pulse, snapshot_program_value}, {1'b1, 7'h07});
      // Mute keys, the second with the far side stalling.
      mute_pair(8'h90, 7'h25, 8'h7F);
      check(mute_state[5], 1'b1);
      slow = 1'b1;
      mute_pair(8'h90, 7'h25, 8'h3F);
      check(mute_state[5], 1'b0);
      slow = 1'b0;
      // Channel selection under the held select key.
      channel_select_key = 1'b1;
      wait_lamp(16'h0001);
      press(7'h22);
      repeat (3) tick();
      check({midi_channel, n_got, mute_state[2]}, {4'h2, 4'h0, 1'b1});
      wait_lamp(16'h0004);
      channel_select_key = 1'b0;
      repeat (8) tick();
      check(group_membership_lamp, 16'h0000);
      mute_pair(8'h92, 7'h25, 8'h7F);
      // Local snapshot recall sends a Program Change.
      clr              = 1'b1;
      snap_recall_req  = 1'b1;
      snap_recall_prog = 7'h0A;
      tick();
      {snap_recall_req, clr} = 2'h0;
      wait_tx_idle();
      check({n_got, got_bytes[15:0]}, {4'h2, 16'hC20A});
      // Traffic on the new channel acts, on the old one it does not.
      rx(8'h92);
      rx(8'h24);
      rx(8'h7F);
      rx(8'h90);
      rx(8'h24);
      rx(8'h3F);
      rx_valid = 1'b0;
      check(mute_state[4], 1'b1);
      // Second reset with the rear selector at serial.
      rst_n              = 1'b0;
      port_select_serial = 1'b1;
      tick();
      tick();
      rst_n = 1'b1;
      check(mute_state, 50'h0);
      repeat (15) tick();
      check(boot_busy, 1'b1);
      wait_boot();
      print_verdict();
   end
endmodule

// ===== tb/mmsh_midi_sink.sv
// Behavioural model of the MIDI port transmitter that takes the handler's bytes.
module mmsh_midi_sink (
   // Clock and reset.
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // Byte stream from the handler.
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_byte,
   output      logic        tx_ready,
   // Bench controls and capture.
   input  wire logic        slow,
   input  wire logic        clr,
   output      logic [63:0] got_bytes,
   output      logic [3:0]  n_got
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [1:0] pace_r;   // Pacing counter for the slow mode.

   // A slow port offers ready one cycle in four, as a busy serial line would.
   // Accepted bytes shift in whole, oldest byte in the highest position.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pace_r    <= 2'h0;
         tx_ready  <= 1'b0;
         got_bytes <= 64'h0;
         n_got     <= 4'h0;
      end else begin
         pace_r   <= pace_r + 2'h1;
         tx_ready <= !slow || (pace_r == 2'h3);
         if (clr) begin
            n_got <= 4'h0;
         end else if (tx_valid && tx_ready) begin
            got_bytes <= {got_bytes[55:0], tx_byte};
            n_got     <= n_got + 4'h1;
         end
      end
   end
endmodule
